// File: hw/fops_top.sv
// Functional notes
// - Options loaded from nonvolatile word; writes ignored.
// - Options bits five to two read zero.
// - Backdoor enable clear blocks key unlock.
// - Eight in-order matching key bytes unlock security.
// - Debug-sourced key writes are not accepted.
// - Redirection disable bit turns off vector redirection.
// - Only security code one-zero means unsecured.
// - Secure state blocks debug memory access.
// - Key unlock or clean blank check sets unsecured.
// - Config bits seven to five writable; rest zero.
// - Key-access bit steers key window writes.
// - Protection loaded at reset; only increase allowed.
// - Protect select ends unprotected region; refuse protected.
// - Protection disable bit removes all protection.
// - Status bits three, one, zero read zero.
// - Writing one to buffer-empty launches command.
// - Only burst program may queue behind another.
// - Complete flag set when idle, cleared on launch.
// - Protected target sets violation; write one clears.
// - Sequence, divider or stop errors set access error.
// - Blank flag set by clean blank check.
// - Program and erase blocked until divider written.
// - Five command codes legal; others access error.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "fops_regs.svh"

module fops_top (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rstn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Access source and power state
	input  wire logic              debug_access,
	input  wire logic              stop_entry,
	// Nonvolatile words
	input  wire fops_pkg::fops_nv_t nv_words,
	// Array sequencer
	output fops_pkg::fops_cmd_t    array_cmd,
	output logic                   array_start,
	input  wire logic              array_done,
	input  wire logic              array_blank,
	output logic                   flash_clock_tick,
	// System state
	output logic                   secure,
	output logic                   redirection_enable,
	output logic                   debug_memory_block
);
	import fops_pkg::*;

	// Register state
	logic       load_pending;
	logic [1:0] opt_high;
	logic [1:0] security_field;
	logic [2:0] config_bits;
	logic [6:0] protect_select;
	logic       protection_disable;
	logic       divider_loaded;
	logic       divider_pre8;
	logic [5:0] divider_value;
	logic       buffer_empty_flag;
	logic       protection_violation_flag;
	logic       access_error_flag;
	logic       blank_flag;
	logic [7:0] command_latch;
	logic [15:0] flash_addr;

	// Sequencer state
	fops_seq_t  seq_state;
	fops_cmd_t  pending;
	logic       buffered;
	logic       running;
	fops_cmd_t  current;

	// Backdoor key state
	logic [3:0] key_index;
	logic       key_match;

	// Divider state
	logic [2:0] pre_count;
	logic [5:0] div_count;

	function automatic logic in_key_window(input logic [15:0] addr);
		in_key_window = (addr >= `FOPS_KEY_BASE) &&
			(addr <= (`FOPS_KEY_BASE + 16'h0007));
	endfunction : in_key_window

	function automatic logic code_is_legal(input logic [7:0] code);
		code_is_legal = (code == `FOPS_CMD_BLANK) || (code == `FOPS_CMD_BYTE_PROG) ||
			(code == `FOPS_CMD_BURST_PROG) || (code == `FOPS_CMD_PAGE_ERASE) ||
			(code == `FOPS_CMD_MASS_ERASE);
	endfunction : code_is_legal

	// Bus access decode
	wire access     = psel && penable;
	wire wr         = access && pwrite;
	wire hit_div    = (paddr == `FOPS_OFS_DIVIDER);
	wire hit_opt    = (paddr == `FOPS_OFS_OPTIONS);
	wire hit_cfg    = (paddr == `FOPS_OFS_CONFIG);
	wire hit_prot   = (paddr == `FOPS_OFS_PROTECT);
	wire hit_stat   = (paddr == `FOPS_OFS_STATUS);
	wire hit_cmd    = (paddr == `FOPS_OFS_COMMAND);
	wire hit_faddr  = (paddr == `FOPS_OFS_FLASH_ADDR);
	wire hit_fdata  = (paddr == `FOPS_OFS_FLASH_DATA);
	wire mapped     = hit_div | hit_opt | hit_cfg | hit_prot | hit_stat |
		hit_cmd | hit_faddr | hit_fdata;

	wire wr_div     = wr && hit_div;
	wire wr_cfg     = wr && hit_cfg;
	wire wr_prot    = wr && hit_prot;
	wire wr_stat    = wr && hit_stat;
	wire wr_cmd     = wr && hit_cmd;
	wire wr_faddr   = wr && hit_faddr;
	wire wr_fdata   = wr && hit_fdata;

	// Security and options decode
	wire key_access     = config_bits[`FOPS_CFG_KEY_ACCESS - 5];
	wire backdoor_enable = opt_high[1];
	assign secure             = (security_field != `FOPS_SEC_UNSECURED);
	assign redirection_enable = !opt_high[0];
	assign debug_memory_block = secure && debug_access;

	// Flash data writes split into key writes and command-sequence writes
	wire key_write   = wr_fdata && key_access && in_key_window(flash_addr);
	wire user_key    = key_write && !debug_access;
	wire array_write = wr_fdata && !key_write;
	wire [2:0] key_slot = flash_addr[2:0];
	wire [7:0] key_byte = nv_words.backdoor_key[63 - 8*key_slot -: 8];
	wire key_close   = wr_cfg && key_access && !pwdata[`FOPS_CFG_KEY_ACCESS];
	wire key_unlock  = key_close && backdoor_enable && key_match &&
		(key_index == 4'(`FOPS_KEY_BYTES));

	// Protection check on the pending command
	// Protected space runs from above the select boundary to the top of the array
	wire is_program  = (pending.code == `FOPS_CMD_BYTE_PROG) ||
		(pending.code == `FOPS_CMD_BURST_PROG);
	wire is_erase    = (pending.code == `FOPS_CMD_PAGE_ERASE) ||
		(pending.code == `FOPS_CMD_MASS_ERASE);
	wire is_burst    = (pending.code == `FOPS_CMD_BURST_PROG);
	wire any_protect = !protection_disable && (protect_select != 7'h7F);
	wire addr_protected = !protection_disable &&
		(pending.addr[15:9] > protect_select);
	wire hits_protect = (pending.code == `FOPS_CMD_MASS_ERASE) ? any_protect :
		((is_program || is_erase) && addr_protected);

	// Launch decode
	// Any launch fault drops the sequence; software restarts at the data write
	wire launch_write = wr_stat && pwdata[`FOPS_ST_BUF_EMPTY];
	wire busy         = running || buffered;
	wire queue_ok     = !busy || (running && !buffered && is_burst &&
		(current.code == `FOPS_CMD_BURST_PROG));
	wire launch_seq_err = launch_write && (seq_state != FOPS_SEQ_CMD);
	wire launch_bad_code = launch_write && (seq_state == FOPS_SEQ_CMD) &&
		!code_is_legal(pending.code);
	wire launch_no_div = launch_write && (is_program || is_erase) &&
		!divider_loaded;
	wire launch_queue_err = launch_write && !queue_ok;
	wire launch_err   = launch_seq_err | launch_bad_code | launch_no_div | launch_queue_err;
	wire launch_pviol = launch_write && !launch_err && hits_protect;
	wire launch_ok    = launch_write && !launch_err && !hits_protect;

	// Sequence errors on data and command writes, stop errors, and the access error set
	wire data_err    = array_write && ((seq_state == FOPS_SEQ_CMD) || !buffer_empty_flag);
	wire cmd_err     = wr_cmd && (seq_state != FOPS_SEQ_DATA);
	wire stop_err    = stop_entry && busy;
	wire set_accerr  = launch_err | data_err | cmd_err | stop_err;

	// Command transfer to the array
	wire transfer    = buffered && (!running || array_done);
	wire blank_done  = array_done && running && (current.code == `FOPS_CMD_BLANK);
	wire blank_clean = blank_done && array_blank;

	// Read data
	wire [7:0] rd_div   = {divider_loaded, divider_pre8, divider_value};
	wire [7:0] rd_opt   = {opt_high, 4'h0, security_field};
	wire [7:0] rd_cfg   = {config_bits, 5'h00};
	wire [7:0] rd_prot  = {protect_select, protection_disable};
	wire complete_flag  = !busy;
	wire [7:0] rd_stat  = {buffer_empty_flag, complete_flag, protection_violation_flag,
		access_error_flag, 1'b0, blank_flag, 2'h0};
	wire [7:0] rd_byte  = hit_div   ? rd_div :
		hit_opt   ? rd_opt :
		hit_cfg   ? rd_cfg :
		hit_prot  ? rd_prot :
		hit_stat  ? rd_stat :
		hit_cmd   ? command_latch :
		hit_fdata ? pending.data : 8'h00;
	wire [31:0] rd_word = hit_faddr ? {16'h0000, flash_addr} : {24'h00_0000, rd_byte};

	assign pready      = 1'b1;
	assign pslverr     = psel && penable && !mapped;
	assign array_cmd   = current;

	// Read data is captured in the setup cycle so that it leaves a flip-flop
	// and still stands through the zero-wait access cycle
	wire rd_setup = psel && !penable && !pwrite && mapped;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			prdata <= 32'h0000_0000;
		else
			prdata <= rd_setup ? rd_word : 32'h0000_0000;
	end

	// Nonvolatile copy on the first edge after reset release
	// An unlocked state lasts only until the next reset reloads the stored code
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			load_pending       <= 1'b1;
			opt_high           <= 2'h0;
			security_field     <= 2'h0;
			protect_select     <= 7'h7F;
			protection_disable <= 1'b0;
		end else if (load_pending) begin
			load_pending       <= 1'b0;
			opt_high           <= {nv_words.options[`FOPS_OPT_BACKDOOR],
				nv_words.options[`FOPS_OPT_NO_REDIR]};
			security_field     <= nv_words.options[`FOPS_OPT_SEC_HI:`FOPS_OPT_SEC_LO];
			protect_select     <= nv_words.protection[7:1];
			protection_disable <= nv_words.protection[`FOPS_PROT_DISABLE];
		end else begin
			if (key_unlock || blank_clean)
				security_field <= `FOPS_SEC_UNSECURED;
			if (wr_prot && !protection_disable &&
					(pwdata[7:1] < protect_select))
				protect_select <= pwdata[7:1];
		end
	end

	// Configuration and clock divider registers
	// The divider takes only its first write; later writes are dropped silently
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			config_bits    <= 3'h0;
			divider_loaded <= 1'b0;
			divider_pre8   <= 1'b0;
			divider_value  <= 6'h00;
		end else begin
			if (wr_cfg)
				config_bits <= pwdata[7:5];
			if (wr_div && !divider_loaded) begin
				divider_loaded <= 1'b1;
				divider_pre8   <= pwdata[`FOPS_DIV_PRE8];
				divider_value  <= pwdata[5:0];
			end
		end
	end

	// Flash clock enable: bus clock over (div+1), optionally over 8 first
	// No tick is issued before the divider has been loaded
	wire pre_tick = !divider_pre8 || (pre_count == 3'h7);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pre_count        <= 3'h0;
			div_count        <= 6'h00;
			flash_clock_tick <= 1'b0;
		end else begin
			pre_count        <= divider_pre8 ? pre_count + 3'h1 : 3'h0;
			flash_clock_tick <= 1'b0;
			if (divider_loaded && pre_tick) begin
				if (div_count >= divider_value) begin
					div_count        <= 6'h00;
					flash_clock_tick <= 1'b1;
				end else begin
					div_count <= div_count + 6'h01;
				end
			end
		end
	end

	// Backdoor key comparison
	// A stray, repeated or out-of-order byte spoils the match until the window closes
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			key_index <= 4'h0;
			key_match <= 1'b1;
		end else if (key_close || !key_access) begin
			key_index <= 4'h0;
			key_match <= 1'b1;
		end else if (user_key) begin
			key_index <= key_index + 4'h1;
			if ((key_index > 4'h7) || (key_slot != key_index[2:0]) ||
					(pwdata[7:0] != key_byte))
				key_match <= 1'b0;
		end
	end

	// Command sequence capture
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			seq_state     <= FOPS_SEQ_IDLE;
			pending       <= '0;
			command_latch <= 8'h00;
			flash_addr    <= 16'h0000;
		end else begin
			if (wr_faddr)
				flash_addr <= pwdata[15:0];
			if (set_accerr) begin
				seq_state <= FOPS_SEQ_IDLE;
			end else if (launch_write) begin
				seq_state <= FOPS_SEQ_IDLE;
			end else if (array_write && seq_state == FOPS_SEQ_IDLE) begin
				seq_state    <= FOPS_SEQ_DATA;
				pending.addr <= flash_addr;
				pending.data <= pwdata[7:0];
			end else if (wr_cmd) begin
				seq_state     <= FOPS_SEQ_CMD;
				pending.code  <= pwdata[7:0];
				command_latch <= pwdata[7:0];
			end
		end
	end

	// Command buffer and array hand-off
	// The buffer is one slot deep; only a burst may wait behind a running burst
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			buffered    <= 1'b0;
			running     <= 1'b0;
			current     <= '0;
			array_start <= 1'b0;
		end else begin
			array_start <= 1'b0;
			if (transfer) begin
				running     <= 1'b1;
				array_start <= 1'b1;
				current     <= pending;
				buffered    <= 1'b0;
			end else if (array_done) begin
				running <= 1'b0;
			end
			if (launch_ok)
				buffered <= 1'b1;
		end
	end

	// Status flags: hardware set wins over a same-cycle software clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			buffer_empty_flag         <= 1'b1;
			protection_violation_flag <= 1'b0;
			access_error_flag         <= 1'b0;
			blank_flag                <= 1'b0;
		end else begin
			if (launch_ok)
				buffer_empty_flag <= 1'b0;
			else if (transfer || (!busy && !buffer_empty_flag))
				buffer_empty_flag <= 1'b1;
			if (launch_pviol)
				protection_violation_flag <= 1'b1;
			else if (wr_stat && pwdata[`FOPS_ST_PVIOL])
				protection_violation_flag <= 1'b0;
			if (set_accerr)
				access_error_flag <= 1'b1;
			else if (wr_stat && pwdata[`FOPS_ST_ACCERR])
				access_error_flag <= 1'b0;
			if (blank_done)
				blank_flag <= array_blank;
			else if (launch_ok)
				blank_flag <= 1'b0;
		end
	end

endmodule : fops_top

// File: shared/fops_pkg.sv
package fops_pkg;

	typedef enum logic [1:0] {
		FOPS_SEQ_IDLE,
		FOPS_SEQ_DATA,
		FOPS_SEQ_CMD
	} fops_seq_t;

	typedef struct packed {
		logic [7:0]  code;
		logic [15:0] addr;
		logic [7:0]  data;
	} fops_cmd_t;

	typedef struct packed {
		logic [7:0]  options;
		logic [7:0]  protection;
		logic [63:0] backdoor_key;
	} fops_nv_t;

endpackage : fops_pkg

// File: shared/fops_regs.svh
`ifndef FOPS_REGS_SVH
`define FOPS_REGS_SVH

// Register byte offsets on the APB slave
`define FOPS_OFS_DIVIDER     12'h000
`define FOPS_OFS_OPTIONS     12'h004
`define FOPS_OFS_CONFIG      12'h008
`define FOPS_OFS_PROTECT     12'h00C
`define FOPS_OFS_STATUS      12'h010
`define FOPS_OFS_COMMAND     12'h014
`define FOPS_OFS_FLASH_ADDR  12'h018
`define FOPS_OFS_FLASH_DATA  12'h01C

// Options register fields
`define FOPS_OPT_BACKDOOR    7
`define FOPS_OPT_NO_REDIR    6
`define FOPS_OPT_SEC_HI      1
`define FOPS_OPT_SEC_LO      0
`define FOPS_SEC_UNSECURED   2'h2

// Configuration register fields
`define FOPS_CFG_KEY_ACCESS  5
`define FOPS_CFG_RW_MASK     8'hE0

// Protection register fields
`define FOPS_PROT_DISABLE    0

// Status register fields
`define FOPS_ST_BUF_EMPTY    7
`define FOPS_ST_COMPLETE     6
`define FOPS_ST_PVIOL        5
`define FOPS_ST_ACCERR       4
`define FOPS_ST_BLANK        2

// Clock divider register fields
`define FOPS_DIV_LOADED      7
`define FOPS_DIV_PRE8        6

// Command codes
`define FOPS_CMD_BLANK       8'h05
`define FOPS_CMD_BYTE_PROG   8'h20
`define FOPS_CMD_BURST_PROG  8'h25
`define FOPS_CMD_PAGE_ERASE  8'h40
`define FOPS_CMD_MASS_ERASE  8'h41

// Backdoor key window
`define FOPS_KEY_BASE        16'hFFB0
`define FOPS_KEY_BYTES       8
`define FOPS_ERASED_BYTE     8'hFF

`endif

// File: verif/fops_top_asserts.sv
`timescale 1ns/1ps
`include "fops_regs.svh"

module fops_top_asserts
	import fops_pkg::*;
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        rstn,
	// APB slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Source, nonvolatile words, sequencer, state
	input wire logic        debug_access,
	input wire logic        stop_entry,
	input wire fops_nv_t    nv_words,
	input wire fops_cmd_t   array_cmd,
	input wire logic        array_start,
	input wire logic        array_done,
	input wire logic        array_blank,
	input wire logic        flash_clock_tick,
	input wire logic        secure,
	input wire logic        redirection_enable,
	input wire logic        debug_memory_block
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	wire logic rd_acc = psel && penable && !pwrite;
	wire logic cfg_wr = psel && penable && pwrite && paddr == `FOPS_OFS_CONFIG;

	a_ready_zero_wait: assert property (pready)
		else $error("pready low");
	a_unmapped_err: assert property (psel && penable && paddr >= 12'h020 |-> pslverr)
		else $error("no error on unmapped access");
	a_opt_fixed: assert property (rd_acc && paddr == `FOPS_OFS_OPTIONS && $past(rstn)
		|-> prdata[7:2] == {nv_words.options[7:6], 4'h0}) else $error("options bits wrong");
	a_cfg_low_zero: assert property (rd_acc && paddr == `FOPS_OFS_CONFIG |-> prdata[4:0] == 5'h00)
		else $error("config low bits not zero");
	a_status_zero: assert property (rd_acc && paddr == `FOPS_OFS_STATUS
		|-> prdata[3] == 1'b0 && prdata[1:0] == 2'h0) else $error("status spare bits set");
	a_redir_follow: assert property ($past(rstn) |-> redirection_enable == !nv_words.options[6])
		else $error("redirection mismatch");
	a_debug_block: assert property (debug_memory_block == (secure && debug_access))
		else $error("debug block mismatch");
	a_legal_code: assert property (array_start
		|-> array_cmd.code inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) else $error("illegal code started");
	a_unsecure_cause: assert property ($fell(secure) && $past(rstn, 2) |-> $past(array_done)
		|| $past(array_done, 2) || $past(cfg_wr) || $past(cfg_wr, 2)) else $error("secure dropped");

	c_start: cover property (array_start);
	c_unsecure: cover property ($fell(secure));
	c_slverr: cover property (pslverr);
endmodule : fops_top_asserts

bind fops_top fops_top_asserts u_asserts (.clock(clock), .rstn(rstn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .debug_access(debug_access), .stop_entry(stop_entry),
	.nv_words(nv_words), .array_cmd(array_cmd), .array_start(array_start),
	.array_done(array_done), .array_blank(array_blank), .flash_clock_tick(flash_clock_tick),
	.secure(secure), .redirection_enable(redirection_enable),
	.debug_memory_block(debug_memory_block));

// File: verif/fops_top_tb_top.sv
`timescale 1ns/1ps
`include "fops_regs.svh"

module fops_top_tb_top;
	import fops_pkg::*;
	logic        clock, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic        debug_access, stop_entry, array_start, array_done, array_blank;
	logic        flash_clock_tick, secure, redirection_enable, debug_memory_block;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	fops_nv_t    nv_words;
	fops_cmd_t   array_cmd;
	int          mismatches, checks, starts, s0, gap;
	logic [7:0]  codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};

	fops_top dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.debug_access(debug_access), .stop_entry(stop_entry), .nv_words(nv_words),
		.array_cmd(array_cmd), .array_start(array_start), .array_done(array_done),
		.array_blank(array_blank), .flash_clock_tick(flash_clock_tick), .secure(secure),
		.redirection_enable(redirection_enable), .debug_memory_block(debug_memory_block));

	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock) if (array_start === 1'b1) starts <= starts + 1;

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// One APB transfer; read data and error taken at the completing edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	task rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(0, a, 0);
		chk(rd, exp, what);
	endtask : rdchk

	task launch(input logic [15:0] fa, input logic [7:0] code);
		apb(1, `FOPS_OFS_FLASH_ADDR, {16'h0000, fa});
		apb(1, `FOPS_OFS_FLASH_DATA, 32'h0000_0055);
		apb(1, `FOPS_OFS_COMMAND, {24'h00_0000, code});
		apb(1, `FOPS_OFS_STATUS, 32'h0000_0080);
	endtask : launch

	task wait_start;
		for (int n = 0; n < 20 && array_start !== 1'b1; n++) @(posedge clock);
	endtask : wait_start

	// Edges from one flash clock tick to the next
	task tick_gap;
		gap = 0;
		for (int n = 0; n < 50 && flash_clock_tick !== 1'b1; n++) @(posedge clock);
		do begin
			@(posedge clock);
			gap++;
		end while (gap < 50 && flash_clock_tick !== 1'b1);
	endtask : tick_gap

	task finish_cmd(input logic blank);
		array_blank <= blank;
		array_done <= 1;
		@(posedge clock);
		array_done <= 0;
	endtask : finish_cmd

	task key_seq(input logic dbg);
		debug_access <= dbg;
		apb(1, `FOPS_OFS_CONFIG, 32'h0000_0020);
		for (int i = 0; i < 8; i++) begin
			apb(1, `FOPS_OFS_FLASH_ADDR, 32'h0000_FFB0 + i);
			apb(1, `FOPS_OFS_FLASH_DATA, {24'h00_0000, nv_words.backdoor_key[63-8*i -: 8]});
		end
		apb(1, `FOPS_OFS_CONFIG, 32'h0000_0000);
		repeat (3) @(posedge clock);
	endtask : key_seq

	task end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	initial begin
		#500000;
		mismatches++;
		end_sim();
	end

	initial begin
		{psel, penable, pwrite, debug_access, stop_entry, array_done, array_blank} = '0;
		paddr = '0;
		pwdata = '0;
		nv_words = '{8'hBC, 8'hE0, 64'h0123_4567_89AB_CDEF};
		rstn = 0;
		repeat (20) @(posedge clock);
		rstn <= 1;
		repeat (2) @(posedge clock);
		rdchk(`FOPS_OFS_STATUS, 32'h0000_00C0, "status reset");
		rdchk(`FOPS_OFS_OPTIONS, 32'h0000_0080, "options reset");
		rdchk(`FOPS_OFS_PROTECT, 32'h0000_00E0, "protect reset");
		chk(redirection_enable, 1, "redirection");
		chk(secure, 1, "secure code 00");
		$display("test reset done");
		apb(1, `FOPS_OFS_OPTIONS, 32'h0000_00FF);
		rdchk(`FOPS_OFS_OPTIONS, 32'h0000_0080, "options write");
		apb(1, `FOPS_OFS_CONFIG, 32'h0000_00FF);
		rdchk(`FOPS_OFS_CONFIG, 32'h0000_00E0, "config write");
		apb(1, `FOPS_OFS_PROTECT, 32'h0000_00F0);
		rdchk(`FOPS_OFS_PROTECT, 32'h0000_00E0, "protect larger");
		apb(1, `FOPS_OFS_PROTECT, 32'h0000_0080);
		rdchk(`FOPS_OFS_PROTECT, 32'h0000_0080, "protect smaller");
		apb(0, 12'h040, 0);
		chk({rd[30:0], err}, 32'h0000_0001, "unmapped");
		$display("test registers done");
		launch(16'h0100, 8'h20);
		rdchk(`FOPS_OFS_STATUS, 32'h0000_00D0, "no divider");
		apb(1, `FOPS_OFS_STATUS, 32'h0000_0010);
		rdchk(`FOPS_OFS_STATUS, 32'h0000_00C0, "accerr clear");
		apb(1, `FOPS_OFS_DIVIDER, 32'h0000_0005);
		apb(1, `FOPS_OFS_DIVIDER, 32'h0000_004A);
		rdchk(`FOPS_OFS_DIVIDER, 32'h0000_0085, "divider once");
		tick_gap();
		chk(gap, 6, "tick period");
		launch(16'h0100, 8'h33);
		rdchk(`FOPS_OFS_STATUS, 32'h0000_00D0, "bad code");
		apb(1, `FOPS_OFS_STATUS, 32'h0000_0010);
		s0 = starts;
		launch(16'hFE00, 8'h20);
		rdchk(`FOPS_OFS_STATUS, 32'h0000_00E0, "protected");
		chk(starts, s0, "protected start");
		apb(1, `FOPS_OFS_STATUS, 32'h0000_0020);
		rdchk(`FOPS_OFS_STATUS, 32'h0000_00C0, "pviol clear");
		$display("test errors done");
		key_seq(1);
		chk(secure, 1, "debug key");
		chk(debug_memory_block, 1, "debug block");
		key_seq(0);
		chk(secure, 0, "user key");
		rdchk(`FOPS_OFS_OPTIONS, 32'h0000_0082, "unsecured code");
		$display("test key done");
		for (int i = 0; i < 5; i++) begin
			launch(16'h0100, codes[i]);
			if (codes[i] == 8'h41) begin
				rdchk(`FOPS_OFS_STATUS, 32'h0000_00E0, "mass erase");
				apb(1, `FOPS_OFS_STATUS, 32'h0000_0020);
			end else begin
				wait_start();
				chk(array_cmd.code, codes[i], "code");
				rdchk(`FOPS_OFS_STATUS, 32'h0000_0080, "busy");
				finish_cmd(i == 0);
				rdchk(`FOPS_OFS_STATUS, i == 0 ? 32'h0000_00C4 : 32'h0000_00C0, "done");
			end
		end
		s0 = starts;
		launch(16'h0100, 8'h25);
		wait_start();
		launch(16'h0102, 8'h25);
		rdchk(`FOPS_OFS_STATUS, 32'h0000_0000, "burst queued");
		finish_cmd(0);
		rdchk(`FOPS_OFS_STATUS, 32'h0000_0080, "burst moved");
		chk(starts, s0 + 2, "burst starts");
		chk(array_cmd.addr, 16'h0102, "burst addr");
		launch(16'h0100, 8'h20);
		rdchk(`FOPS_OFS_STATUS, 32'h0000_0090, "busy refuse");
		apb(1, `FOPS_OFS_STATUS, 32'h0000_0010);
		stop_entry <= 1;
		@(posedge clock);
		stop_entry <= 0;
		rdchk(`FOPS_OFS_STATUS, 32'h0000_0090, "stop busy");
		finish_cmd(0);
		apb(1, `FOPS_OFS_STATUS, 32'h0000_0010);
		rdchk(`FOPS_OFS_STATUS, 32'h0000_00C0, "idle");
		$display("test commands done");
		rstn <= 0;
		nv_words <= '{8'h43, 8'hE1, 64'h0123_4567_89AB_CDEF};
		repeat (3) @(posedge clock);
		rstn <= 1;
		repeat (2) @(posedge clock);
		chk(secure, 1, "relocked");
		chk(redirection_enable, 0, "no redirection");
		rdchk(`FOPS_OFS_OPTIONS, 32'h0000_0043, "options reload");
		apb(1, `FOPS_OFS_PROTECT, 32'h0000_0080);
		rdchk(`FOPS_OFS_PROTECT, 32'h0000_00E1, "protect disabled");
		apb(1, `FOPS_OFS_DIVIDER, 32'h0000_0005);
		s0 = starts;
		launch(16'hFFB0, 8'h20);
		wait_start();
		chk(array_cmd.addr, 16'hFFB0, "key window program");
		finish_cmd(0);
		chk(starts, s0 + 1, "unprotected start");
		key_seq(0);
		chk(secure, 1, "backdoor disabled");
		$display("test second reset done");
		end_sim();
	end
endmodule : fops_top_tb_top
